// *** rtl/wdrc_pkg.sv ***
package wdrc_pkg;

  // Register indices; byte address is four times the index
  localparam int          IDX_W        = 16;
  localparam int          ADDR_W       = IDX_W + 2;
  localparam [IDX_W-1:0]  IDX_CTRL     = 16'h0000;
  localparam [IDX_W-1:0]  IDX_STAT     = 16'h0001;
  localparam [IDX_W-1:0]  IDX_MASK     = 16'h0002;
  localparam [IDX_W-1:0]  IDX_CNT      = 16'h0003;
  localparam [IDX_W-1:0]  IDX_CLEAR    = 16'hFFFF;

  // Control register fields
  localparam int          CTRL_RATE    = 0;
  localparam int          CTRL_DIS     = 1;
  localparam int          CTRL_PIN     = 2;
  localparam int          CTRL_BRK     = 3;
  localparam int          CTRL_W       = 4;
  localparam [3:0]        CTRL_RST     = 4'h0;

  // Status and mask fields
  localparam int          ST_OVF       = 0;
  localparam int          ST_CLR       = 1;
  localparam int          ST_W         = 2;
  localparam [1:0]        ST_RST       = 2'h0;
  localparam [1:0]        MASK_RST     = 2'h0;

  // Counter shape and timeouts in fast clock cycles
  localparam int          PRESC_W      = 12;
  localparam int          WD_W         = 6;
  localparam int          KEEP_LOW     = 4;
  localparam int          TMO_LONG     = 262128;
  localparam int          TMO_SHORT    = 8176;
  localparam int          RST_PIN_CYC  = 32;
  localparam int          POR_CYC      = 4096;

  localparam [1:0]        RESP_OKAY    = 2'h0;
  localparam [1:0]        RESP_SLVERR  = 2'h2;

endpackage : wdrc_pkg

// *** rtl/wdrc_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module wdrc_timer #(
  parameter int PRESC_W   = 12,
  parameter int WD_W      = 6,
  parameter int KEEP_LOW  = 4,
  parameter int TMO_LONG  = 262128,
  parameter int TMO_SHORT = 8176
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               count_en,
  input  wire logic               wd_en,
  input  wire logic               rate_sel,
  input  wire logic               clr_upper,
  input  wire logic               clr_presc,
  input  wire logic               clr_all,
  output logic      [PRESC_W-1:0] presc,
  output logic      [WD_W-1:0]    wd_cnt,
  output logic                    ovf
);
  localparam int PER_LONG  = (TMO_LONG + 2**KEEP_LOW) / 2**WD_W;
  localparam int PER_SHORT = (TMO_SHORT + 2**KEEP_LOW) / 2**WD_W;
  localparam int CMP_LONG  = TMO_LONG - (2**WD_W - 1) * PER_LONG - 1;
  localparam int CMP_SHORT = TMO_SHORT - (2**WD_W - 1) * PER_SHORT - 1;

  if (PER_LONG != 2**PRESC_W || PER_SHORT > PER_LONG || CMP_SHORT < 0)
    $error("wdrc_timer: timeouts do not fit the counter shape");

  typedef struct packed {
    logic [PRESC_W-1:0] presc;
    logic [WD_W-1:0]    wd;
    logic               ovf;
  } wdrc_tmr_t;

  wdrc_tmr_t q;
  wdrc_tmr_t d;
  logic      [PRESC_W-1:0] low;
  logic      [PRESC_W-1:0] per_m1;
  logic      [PRESC_W-1:0] cmp;

  always_comb begin
    d      = q;
    d.ovf  = 1'b0;
    per_m1 = rate_sel ? PRESC_W'(PER_SHORT - 1) : PRESC_W'(PER_LONG - 1);
    cmp    = rate_sel ? PRESC_W'(CMP_SHORT) : PRESC_W'(CMP_LONG);
    low    = q.presc & per_m1;
    if (count_en) begin
      d.presc = q.presc + 1'b1;
      if (low == per_m1)
        d.wd = q.wd + 1'b1;
      if (wd_en && q.wd == {WD_W{1'b1}} && low == cmp) begin
        d.ovf   = 1'b1;
        d.presc = '0;
        d.wd    = '0;
      end
    end
    if (clr_upper) begin
      d.presc[PRESC_W-1:KEEP_LOW] = '0;
      d.wd                        = '0;
    end
    if (clr_presc)
      d.presc = '0;
    if (clr_all) begin
      d.presc = '0;
      d.wd    = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  assign presc  = q.presc;
  assign wd_cnt = q.wd;
  assign ovf    = q.ovf;
endmodule : wdrc_timer
`default_nettype wire

// *** rtl/wdrc_stretch.sv ***
`timescale 1ns/100ps
`default_nettype none
module wdrc_stretch #(
  parameter int CYCLES = 32
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic trigger,
  input  wire logic pin_en,
  output logic      pin_out,
  output logic      pin_oe_n
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1)
    $error("wdrc_stretch: CYCLES must be at least one");

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
    logic          oe_n;
  } wdrc_str_t;

  wdrc_str_t q;
  wdrc_str_t d;

  always_comb begin
    d = q;
    if (trigger && pin_en)
      d.cnt = CW'(CYCLES);
    else if (q.cnt != '0)
      d.cnt = q.cnt - 1'b1;
    d.oe_n = (d.cnt == '0);
    d.out  = (d.cnt == '0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      q <= '{cnt: '0, out: 1'b1, oe_n: 1'b1};
    else
      q <= d;
  end

  assign pin_out  = q.out;
  assign pin_oe_n = q.oe_n;
endmodule : wdrc_stretch
`default_nettype wire

// *** rtl/wdrc_top.sv ***
// Overview of operation
// - 6-bit counter advances from 12-bit prescaler.
// - Uncleared overflow resets after selected timeout.
// - Rate bit one short, zero long timeout.
// - Clear write zeroes counter, prescaler stages 12-5.
// - Clear write starts new timeout, less prescaler stages 4-1.
// - Clear address reads reset vector low byte.
// - Overflow drives pin 32 cycles, sets cause.
// - Stop clears prescaler and halts counting.
// - Prescaler cleared 4096 cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Disable bit stops overflow resets.
// - Disable bit one disables, zero enables.
// - Overflow raises irq only while its mask bit is set.
// - Monitor mode with test voltage disables.
// - Counting continues during wait mode.
// - Break in monitor with bit set disables.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module wdrc_top #(
  parameter int POR_CYCLES = wdrc_pkg::POR_CYC
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [wdrc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [wdrc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [7:0]                  reset_vector_lo,
  input  wire logic                        stop_enter,
  input  wire logic                        stop_mode,
  input  wire logic                        monitor_mode,
  input  wire logic                        test_voltage,
  input  wire logic                        break_active,
  input  wire logic                        internal_reset,
  input  wire logic                        rst_pin_in,
  output logic                             rst_pin_out,
  output logic                             rst_pin_oe_n,
  output logic                             system_reset_req,
  output logic                             irq
);
  import wdrc_pkg::*;

  localparam int PCW = $clog2(POR_CYCLES + 1);

  if (POR_CYCLES < 1)
    $error("wdrc_top: POR_CYCLES must be at least one");

  localparam [ADDR_W-1:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
  localparam [ADDR_W-1:0] ADDR_STAT  = {IDX_STAT, 2'b00};
  localparam [ADDR_W-1:0] ADDR_MASK  = {IDX_MASK, 2'b00};
  localparam [ADDR_W-1:0] ADDR_CNT   = {IDX_CNT, 2'b00};
  localparam [ADDR_W-1:0] ADDR_CLEAR = {IDX_CLEAR, 2'b00};

  typedef enum logic [2:0] {
    SEL_CTRL  = 3'b000,
    SEL_STAT  = 3'b001,
    SEL_MASK  = 3'b010,
    SEL_CNT   = 3'b011,
    SEL_CLEAR = 3'b100,
    SEL_NONE  = 3'b111
  } wdrc_sel_t;

  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              awready;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [CTRL_W-1:0] ctrl;
    logic [ST_W-1:0]   stat;
    logic [ST_W-1:0]   mask;
    logic              irq;
    logic [PCW-1:0]    por_cnt;
    logic              por_clr;
    logic              wd_clr;
    logic              sys_rst;
  } wdrc_regs_t;

  wdrc_regs_t q;
  wdrc_regs_t d;

  logic               wd_en;
  logic               tmr_ovf;
  logic [PRESC_W-1:0] presc;
  logic [WD_W-1:0]    wd_cnt;
  logic [ST_W-1:0]    st_set;
  logic [ST_W-1:0]    st_clr;
  wdrc_sel_t          wsel;
  wdrc_sel_t          rsel;

  function automatic wdrc_sel_t decode(input logic [ADDR_W-1:0] a);
    wdrc_sel_t s;
    if (a == ADDR_CTRL)
      s = SEL_CTRL;
    else if (a == ADDR_STAT)
      s = SEL_STAT;
    else if (a == ADDR_MASK)
      s = SEL_MASK;
    else if (a == ADDR_CNT)
      s = SEL_CNT;
    else if (a == ADDR_CLEAR)
      s = SEL_CLEAR;
    else
      s = SEL_NONE;
    return s;
  endfunction : decode

  // Watchdog gating by configuration, monitor and break
  assign wd_en = !q.ctrl[CTRL_DIS]
               && !(monitor_mode && test_voltage)
               && !(monitor_mode && break_active
                    && q.ctrl[CTRL_BRK]);

  wdrc_timer #(
    .PRESC_W   (PRESC_W),
    .WD_W      (WD_W),
    .KEEP_LOW  (KEEP_LOW),
    .TMO_LONG  (TMO_LONG),
    .TMO_SHORT (TMO_SHORT)
  ) u_timer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .count_en  (!stop_mode),
    .wd_en     (wd_en),
    .rate_sel  (q.ctrl[CTRL_RATE]),
    .clr_upper (q.wd_clr),
    .clr_presc (stop_enter || q.por_clr),
    .clr_all   (internal_reset || q.sys_rst),
    .presc     (presc),
    .wd_cnt    (wd_cnt),
    .ovf       (tmr_ovf)
  );

  wdrc_stretch #(
    .CYCLES   (RST_PIN_CYC)
  ) u_stretch (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .trigger  (tmr_ovf),
    .pin_en   (q.ctrl[CTRL_PIN]),
    .pin_out  (rst_pin_out),
    .pin_oe_n (rst_pin_oe_n)
  );

  always_comb begin
    d         = q;
    d.wd_clr  = 1'b0;
    d.por_clr = 1'b0;
    st_set    = '0;
    st_clr    = '0;
    wsel      = decode(q.aw_addr);
    rsel      = decode(s_axi_araddr);

    // One-shot prescaler clear after power-up settling time
    if (q.por_cnt != PCW'(POR_CYCLES)) begin
      d.por_cnt = q.por_cnt + 1'b1;
      if (q.por_cnt == PCW'(POR_CYCLES - 1))
        d.por_clr = 1'b1;
    end

    // Overflow is a single reset request pulse
    d.sys_rst      = tmr_ovf;
    st_set[ST_OVF] = tmr_ovf;

    // Write address and data are taken independently
    if (s_axi_awvalid && q.awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end

    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (wsel == SEL_CTRL) begin
        if (q.w_strb[0])
          d.ctrl = q.w_data[CTRL_W-1:0];
      end else if (wsel == SEL_STAT) begin
        if (q.w_strb[0])
          st_clr = q.w_data[ST_W-1:0];
      end else if (wsel == SEL_MASK) begin
        if (q.w_strb[0])
          d.mask = q.w_data[ST_W-1:0];
      end else if (wsel == SEL_CLEAR) begin
        d.wd_clr       = 1'b1;
        st_set[ST_CLR] = 1'b1;
      end else if (wsel == SEL_CNT) begin
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end

    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;

    // Read channel; no read has a side effect
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = RESP_OKAY;
      d.rdata   = '0;
      if (rsel == SEL_CTRL)
        d.rdata[CTRL_W-1:0] = q.ctrl;
      else if (rsel == SEL_STAT)
        d.rdata[ST_W-1:0] = q.stat;
      else if (rsel == SEL_MASK)
        d.rdata[ST_W-1:0] = q.mask;
      else if (rsel == SEL_CNT)
        d.rdata[PRESC_W+WD_W+1:0] = {rst_pin_in, wd_en, wd_cnt, presc};
      else if (rsel == SEL_CLEAR)
        d.rdata[7:0] = reset_vector_lo;
      else
        d.rresp = RESP_SLVERR;
    end

    // Sticky status; a new event outranks a clear
    d.stat = (q.stat & ~st_clr) | st_set;
    d.irq  = |(d.stat & q.mask);
    if (wsel == SEL_MASK && q.aw_got && q.w_got && !q.bvalid
        && q.w_strb[0])
      d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      q.ctrl    <= CTRL_RST;
      q.stat    <= ST_RST;
      q.mask    <= MASK_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready    = q.awready;
  assign s_axi_wready     = q.wready;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_arready    = q.arready;
  assign s_axi_rvalid     = q.rvalid;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign system_reset_req = q.sys_rst;
  assign irq              = q.irq;
endmodule : wdrc_top
`default_nettype wire

// *** verification/wdrc_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module wdrc_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        system_reset_req,
  input wire logic        rst_pin_out,
  input wire logic        rst_pin_oe_n
);
  logic [5:0] low_q;
  logic [5:0] low_d;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Length of the current pin drive
  always_comb low_d = rst_pin_oe_n ? 6'h0 : low_q + 6'h1;
  always_ff @(posedge aclk) low_q <= aresetn ? low_d : 6'h0;
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_req_single;
    system_reset_req |=> !system_reset_req;
  endproperty
  property p_pin_len;
    $rose(rst_pin_oe_n) |-> low_q == 6'h20;
  endproperty
  property p_pin_max;
    low_q <= 6'h20;
  endproperty
  property p_pin_start;
    $fell(rst_pin_oe_n) |-> system_reset_req;
  endproperty
  property p_pin_low;
    !rst_pin_oe_n |-> !rst_pin_out;
  endproperty
  property p_wr_lat;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_wr_busy;
    s_wr_take |=> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  property p_rd_lat;
    s_rd_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_req_single: assert property (p_req_single)
    else $error("reset request wider than one cycle");
  a_pin_len: assert property (p_pin_len)
    else $error("pin drive length wrong");
  a_pin_max: assert property (p_pin_max)
    else $error("pin driven too long");
  a_pin_start: assert property (p_pin_start)
    else $error("pin drive without reset request");
  a_pin_low: assert property (p_pin_low)
    else $error("driven pin not low");
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response late");
  a_wr_busy: assert property (p_wr_busy)
    else $error("write ready not dropped");
  a_b_done: assert property (p_b_done)
    else $error("write response not closed");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
endmodule : wdrc_checker
bind wdrc_top wdrc_checker u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .system_reset_req(system_reset_req), .rst_pin_out(rst_pin_out),
  .rst_pin_oe_n(rst_pin_oe_n)
);
`default_nettype wire

// *** verification/test_watchdog_reset_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_watchdog_reset_counter;
  import wdrc_pkg::*;
  logic              aclk, aresetn, awvalid, awready, wvalid, wready;
  logic              bvalid, bready, arvalid, arready, rvalid, rready;
  logic              stop_enter, stop_mode, monitor_mode, test_voltage;
  logic              break_active, internal_reset, rst_pin_out;
  logic              rst_pin_oe_n, system_reset_req, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [7:0]        rvec;
  wire logic         rst_pin_in;
  int                error_cnt, checks_done, cyc;
  // Pin has a pull-up when nobody drives it
  assign rst_pin_in = rst_pin_oe_n ? 1'b1 : rst_pin_out;
  wdrc_top #(.POR_CYCLES(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .reset_vector_lo(rvec),
    .stop_enter(stop_enter), .stop_mode(stop_mode),
    .monitor_mode(monitor_mode), .test_voltage(test_voltage),
    .break_active(break_active), .internal_reset(internal_reset),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n), .system_reset_req(system_reset_req),
    .irq(irq)
  );
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // Cycles until a reset request, or -1
  task automatic watch(input int n, output int seen);
    seen = -1;
    for (int i = 0; i < n && seen < 0; i++) begin
      @(posedge aclk);
      if (system_reset_req === 1'b1) seen = i;
    end
  endtask : watch
  task automatic test_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(IDX_CTRL, d, r);
    chk("ctrl reset", CTRL_RST, d);
    rd(IDX_STAT, d, r);
    chk("stat reset", ST_RST, d);
    rd(IDX_MASK, d, r);
    chk("mask reset", MASK_RST, d);
    rd(16'h0010, d, r);
    chk("unmapped read", RESP_SLVERR, r);
    wr(16'h0010, 32'h0000_0003, r);
    chk("unmapped write", RESP_SLVERR, r);
    chk("idle pin", 1, rst_pin_oe_n);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_ovf;
    logic [31:0] d;
    logic [1:0]  r;
    int          t, n;
    wr(IDX_CTRL, 32'h0000_0005, r);
    wr(IDX_CLEAR, 32'h0000_0000, r);
    watch(6000, t);
    chk("early reset", 32'hFFFF_FFFF, t);
    wr(IDX_CLEAR, 32'h1234_5678, r);
    watch(TMO_SHORT + 40, t);
    chk("timeout", 1, t >= TMO_SHORT - 20 && t <= TMO_SHORT + 5);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      n += (rst_pin_oe_n === 1'b0 && rst_pin_out === 1'b0);
      @(posedge aclk);
    end
    chk("pin low cycles", 32, n);
    chk("no interrupt", 0, irq);
    rd(IDX_STAT, d, r);
    chk("cause flag", 1, d[ST_OVF]);
    wr(IDX_MASK, 32'h0000_0001, r);
    repeat (3) @(posedge aclk);
    chk("irq set", 1, irq);
    wr(IDX_STAT, 32'h0000_0001, r);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 0, irq);
    wr(IDX_MASK, 32'h0000_0000, r);
    $display("test_ovf done");
  endtask : test_ovf
  task automatic test_disable;
    logic [1:0] r;
    int         t;
    for (int i = 0; i < 3; i++) begin
      // Modes first, so the watchdog is never briefly enabled
      monitor_mode <= i > 0;
      test_voltage <= i == 1;
      break_active <= i == 2;
      wr(IDX_CTRL, i == 0 ? 32'h0000_0003 : 32'h0000_0009, r);
      wr(IDX_CLEAR, 32'h0000_0000, r);
      watch(TMO_SHORT + 300, t);
      chk("disabled reset", 32'hFFFF_FFFF, t);
    end
    monitor_mode <= 1'b0;
    test_voltage <= 1'b0;
    break_active <= 1'b0;
    $display("test_disable done");
  endtask : test_disable
  task automatic test_stop;
    logic [31:0] a, d;
    logic [1:0]  r;
    wr(IDX_CTRL, 32'h0000_0000, r);
    wr(IDX_CLEAR, 32'h0000_0000, r);
    repeat (5000) @(posedge aclk);
    stop_mode <= 1'b1;
    rd(IDX_CNT, a, r);
    rd(IDX_CLEAR, d, r);
    chk("vector byte", rvec, d[7:0]);
    rd(IDX_CNT, d, r);
    chk("frozen count", a[17:0], d[17:0]);
    chk("pin level", 1, d[19]);
    stop_enter <= 1'b1;
    @(posedge aclk);
    stop_enter <= 1'b0;
    rd(IDX_CNT, d, r);
    chk("stop prescaler", 0, d[11:0]);
    internal_reset <= 1'b1;
    @(posedge aclk);
    internal_reset <= 1'b0;
    rd(IDX_CNT, d, r);
    chk("internal reset", 0, d[17:0]);
    stop_mode <= 1'b0;
    wr(IDX_CLEAR, 32'h0000_0000, r);
    chk("clear after stop", RESP_OKAY, r);
    $display("test_stop done");
  endtask : test_stop
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 70000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {stop_enter, stop_mode, monitor_mode, test_voltage} = '0;
    {break_active, internal_reset} = '0;
    {awaddr, araddr, wdata} = '0;
    rvec = 8'hA5;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_ovf();
    test_disable();
    test_stop();
    summarize();
  end
endmodule : test_watchdog_reset_counter
`default_nettype wire
